// [hw/link_test_map.svh]
/*
  Offsets, field positions, reset values and pattern constants of the
  per-channel test and loopback block. Assumes a 5-bit register number.
*/
`ifndef LINK_TEST_MAP_SVH
`define LINK_TEST_MAP_SVH

`define REG_CTRL        5'h00
`define REG_STAT        5'h01
`define REG_CH0         5'h10
`define REG_CH1         5'h11
`define REG_TPC         5'h14
`define REG_TPS         5'h15
`define REG_TPE         5'h16
`define REG_CRH         5'h17
`define REG_CRL         5'h18
`define REG_PRH         5'h1d
`define REG_PRL         5'h1f

`define CTRL_SOFT_RST   15
`define CTRL_DEEP_LOOP  14
`define CTRL_RATE_LO    13
`define CTRL_ANEG       12
`define CTRL_PAR_HIZ    10
`define CTRL_RATE_HI    6
`define CTRL_MASK       16'h7440
`define CTRL_RST        16'h1040
`define STAT_LINK       2

`define CH0_PCS_EN      12
`define CH0_SHALLOW     9
`define CH0_FAR_END     8
`define CH0_PRBS_VER    7
`define CH0_PRBS_GEN    6
`define CH0_AUTO_RATE   5
`define CH0_COMMA       2
`define CH0_MASK        16'h13e4
`define CH0_RST         16'h1024
`define CH1_RX_DEC      2
`define CH1_MASK        16'h0004
`define CH1_RST         16'h0004

`define TPC_GEN_EN      4
`define TPC_VER_EN      3
`define TPC_MASK        16'h001f
`define TPS_CRPAT_SYNC  0
`define TPS_FIXED_SYNC  1

`define PAT_HIGH        3'h0
`define PAT_LOW         3'h1
`define PAT_MIXED       3'h2
`define PAT_CR_LONG     3'h3
`define PAT_CR_SHORT    3'h4

`define CHAR_HIGH       10'h155
`define CHAR_LOW        10'h0f8
`define CHAR_MIX_A      10'h0fa
`define CHAR_MIX_B      10'h305
`define CHAR_IDLE       10'h3c5
`define CHAR_PRE        10'h2aa
`define CHAR_SFD        10'h2ab
`define CR_PRE_LEN      8'h07
`define CR_LONG_LEN     8'hff
`define CR_SHORT_LEN    8'h40
`define CR_GAP_LEN      8'h0c
`define CR_SALT         8'h5a

`define PRBS_SEED       7'h7f
`define PRBS_CNT_RST    16'hfffd
`define TPE_CNT_RST     16'h0000
`define CR_CNT_RST      32'h0000_0000

`endif

// [hw/link_test_pkg.sv]
/*
  Types shared by the test and loopback block. Assumes nothing else.
*/
package link_test_pkg;
  typedef logic [9:0] char_t;
  typedef enum logic [1:0] {CR_GAP, CR_PRE, CR_SFD, CR_DATA} crpat_state_e;
endpackage : link_test_pkg

// [hw/sat_counter.sv]
/*
  Saturating error counter that clears on a read strobe.
  Assumes the clear and the increment come from the same clock domain.
*/
module sat_counter #(
  parameter int unsigned W = 16,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Events
  input  wire logic         inc_i,
  input  wire logic         clr_i,
  // Value
  output logic [W-1:0]      count_o
);
  // An error in the cycle of the read is kept, so the count restarts at one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= RST;
    end else if (clr_i) begin
      count_o <= inc_i ? W'(1) : '0;
    end else if (inc_i && count_o != {W{1'b1}}) begin
      count_o <= count_o + W'(1);
    end
  end
endmodule : sat_counter

// [hw/link_test_pattern_loopback.sv]
/*
  One channel's test pattern, pseudo-random sequence and loopback logic
  with its management registers. Assumes 10-bit characters on both the
  parallel and the serial side, one per clock, and a register master on
  clk_i. Serial receive characters and the loop pin come from outside.
*/
// Notes on behaviour
// - Writing bit 15 at location 0 soft-resets; location 1 bit 2 shows link.
// - Pattern field 20[2:0]: 000 high, 001 low, 010 mixed frequency.
// - Pattern field 011 selects long, 100 short random packet pattern.
// - Bit 20.4 transmits the chosen pattern until software clears it.
// - Bit 20.3, with bit 20.4 set, starts checking received pattern against the chosen one.
// - Fixed verifier counts only after sync, shown on bit 21.1.
// - Packets carry preamble and delimiter; verifier syncs on it, bit 21.0.
// - Fixed errors count in register 22; reading clears without stopping test.
// - Packet error count: 23 upper, 24 lower, coherent when 23 read first.
// - Pattern checking runs until bit 20.4 is cleared.
// - Bit 16.6 enables the pseudo-random transmit generator.
// - Bit 16.7 enables the pseudo-random receive verifier.
// - Pseudo-random errors go to 29 at gigabit, 31 at fiber rate.
// - Pseudo-random test runs until both enables clear; reads only clear.
// - Clearing 16.12 disables coding sublayer, clearing 16.2 comma detect.
// - Clearing 17.2 disables the gigabit receive decoder.
// - 0.6 high, 0.13 low is gigabit; 0.6 low, 0.13 high is fiber.
// - Bit 0.14 or the loop pin loops serial transmit in; output floats.
// - Bit 16.9 loops parallel transmit onto parallel receive.
// - Bit 16.8 loops serial receive to serial output; parallel input ignored.
// - During far-end loopback bit 0.10 floats the parallel outputs.
// - Sequence counters add one per bad character, saturate, clear on read.
// - The sequence is the seven-stage maximal-length one, period 127.
`include "link_test_map.svh"

module link_test_pattern_loopback
  import link_test_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [4:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  // Parallel side
  input  wire logic [9:0]  tx_data_i,
  output logic [9:0]       rx_data_o,
  output logic             rx_oe_n_o,
  // Serial side
  input  wire logic [9:0]  ser_rx_i,
  output logic [9:0]       ser_tx_o,
  output logic             ser_tx_oe_n_o,
  // Pins
  input  wire logic        all_channel_loop_pin_i,
  input  wire logic        link_ok_i,
  // Static controls
  output logic             pcs_enable_o,
  output logic             comma_detect_o,
  output logic             rx_decode_en_o,
  output logic             auto_neg_en_o,
  output logic             auto_rate_en_o
);

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    return a == r;
  endfunction : hit

  // Ten steps of x^7 + x^6 + 1; returns the new state above the character.
  function automatic logic [16:0] prbs_step(input logic [6:0] s);
    logic [6:0] st;
    logic [9:0] ch;
    logic       b;
    st = s;
    ch = '0;
    b  = 1'b0;
    for (int i = 0; i < 10; i++) begin
      b = st[6] ^ st[5];
      st = {st[5:0], b};
      ch[9-i] = b;
    end
    return {st, ch};
  endfunction : prbs_step

  // Payload is a fixed function of position, so the verifier needs no seed.
  function automatic char_t cr_payload(input logic [7:0] idx);
    return {2'b01, idx ^ `CR_SALT};
  endfunction : cr_payload

  // Synchronisers
  char_t      ser_rx_s1;
  char_t      ser_rx_s2;
  logic       loop_s1;
  logic       loop_s2;
  logic       link_s1;
  logic       link_s2;

  always_ff @(posedge clk_i) begin
    ser_rx_s1 <= ser_rx_i;
    ser_rx_s2 <= ser_rx_s1;
    loop_s1   <= all_channel_loop_pin_i;
    loop_s2   <= loop_s1;
    link_s1   <= link_ok_i;
    link_s2   <= link_s1;
  end

  // Registers
  logic [15:0] ctrl;
  logic [15:0] ch0;
  logic [15:0] ch1;
  logic [15:0] tpc;
  logic        soft_rst;
  logic [15:0] cr_lo_shadow;
  logic        srst;

  wire wr_ctrl = wr_i && hit(addr_i, `REG_CTRL);
  wire rd_tpe  = rd_i && hit(addr_i, `REG_TPE);
  wire rd_crh  = rd_i && hit(addr_i, `REG_CRH);
  wire rd_prh  = rd_i && hit(addr_i, `REG_PRH);
  wire rd_prl  = rd_i && hit(addr_i, `REG_PRL);

  assign srst = rst_i || soft_rst;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_ctrl && wdata_i[`CTRL_SOFT_RST];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst) begin
      ctrl <= `CTRL_RST;
      ch0  <= `CH0_RST;
      ch1  <= `CH1_RST;
      tpc  <= '0;
    end else if (wr_i) begin
      if (wr_ctrl && !wdata_i[`CTRL_SOFT_RST]) ctrl <= wdata_i & `CTRL_MASK;
      if (hit(addr_i, `REG_CH0)) ch0 <= wdata_i & `CH0_MASK;
      if (hit(addr_i, `REG_CH1)) ch1 <= wdata_i & `CH1_MASK;
      if (hit(addr_i, `REG_TPC)) tpc <= wdata_i & `TPC_MASK;
    end
  end

  // Mode decode
  wire [2:0] pat_sel    = tpc[2:0];
  wire       gen_on     = tpc[`TPC_GEN_EN];
  wire       ver_on     = tpc[`TPC_VER_EN] && gen_on;
  wire       cr_mode    = pat_sel == `PAT_CR_LONG || pat_sel == `PAT_CR_SHORT;
  wire       fix_mode   = pat_sel <= `PAT_MIXED;
  wire [7:0] cr_len     = pat_sel == `PAT_CR_LONG ? `CR_LONG_LEN : `CR_SHORT_LEN;
  wire       rate_1g    = ctrl[`CTRL_RATE_HI] && !ctrl[`CTRL_RATE_LO];
  wire       rate_fx    = !ctrl[`CTRL_RATE_HI] && ctrl[`CTRL_RATE_LO];
  wire       deep       = ctrl[`CTRL_DEEP_LOOP] || loop_s2;
  wire       far        = ch0[`CH0_FAR_END];
  wire       prbs_gen   = ch0[`CH0_PRBS_GEN];
  wire       prbs_ver   = ch0[`CH0_PRBS_VER];

  // Fixed pattern generator
  logic  mix_phase;
  char_t fix_char;

  assign fix_char = pat_sel == `PAT_HIGH ? `CHAR_HIGH :
                    pat_sel == `PAT_LOW  ? `CHAR_LOW  :
                    mix_phase ? `CHAR_MIX_B : `CHAR_MIX_A;

  always_ff @(posedge clk_i) begin
    if (srst || !gen_on) begin
      mix_phase <= 1'b0;
    end else begin
      mix_phase <= !mix_phase;
    end
  end

  // Random packet generator
  crpat_state_e cg_state;
  logic [7:0]   cg_cnt;
  char_t        cr_char;

  always_ff @(posedge clk_i) begin
    if (srst || !gen_on || !cr_mode) begin
      cg_state <= CR_GAP;
      cg_cnt   <= '0;
    end else begin
      unique case (cg_state)
        CR_GAP: begin
          cg_cnt   <= cg_cnt == `CR_GAP_LEN - 8'h01 ? '0 : cg_cnt + 8'h01;
          if (cg_cnt == `CR_GAP_LEN - 8'h01) cg_state <= CR_PRE;
        end
        CR_PRE: begin
          cg_cnt   <= cg_cnt == `CR_PRE_LEN - 8'h01 ? '0 : cg_cnt + 8'h01;
          if (cg_cnt == `CR_PRE_LEN - 8'h01) cg_state <= CR_SFD;
        end
        CR_SFD: begin
          cg_state <= CR_DATA;
        end
        CR_DATA: begin
          cg_cnt   <= cg_cnt == cr_len - 8'h01 ? '0 : cg_cnt + 8'h01;
          if (cg_cnt == cr_len - 8'h01) cg_state <= CR_GAP;
        end
      endcase
    end
  end

  always_comb begin
    unique case (cg_state)
      CR_GAP:  cr_char = `CHAR_IDLE;
      CR_PRE:  cr_char = `CHAR_PRE;
      CR_SFD:  cr_char = `CHAR_SFD;
      CR_DATA: cr_char = cr_payload(cg_cnt);
    endcase
  end

  // Pseudo-random generator
  logic [6:0]  prbs_state;
  logic [16:0] prbs_tx;

  assign prbs_tx = prbs_step(prbs_state);

  always_ff @(posedge clk_i) begin
    if (srst || !prbs_gen) begin
      prbs_state <= `PRBS_SEED;
    end else begin
      prbs_state <= prbs_tx[16:10];
    end
  end

  // Transmit selection and loopback paths
  char_t tx_q;
  char_t rx_char;
  char_t next_tx;

  assign next_tx = far      ? ser_rx_s2 :
                   prbs_gen ? prbs_tx[9:0] :
                   gen_on   ? (cr_mode ? cr_char : fix_char) :
                   tx_data_i;
  assign rx_char = deep ? tx_q : ser_rx_s2;

  always_ff @(posedge clk_i) begin
    if (srst) begin
      tx_q          <= '0;
      rx_data_o     <= '0;
      rx_oe_n_o     <= 1'b0;
      ser_tx_oe_n_o <= 1'b0;
    end else begin
      tx_q          <= next_tx;
      rx_data_o     <= ch0[`CH0_SHALLOW] ? tx_data_i : rx_char;
      rx_oe_n_o     <= far && ctrl[`CTRL_PAR_HIZ];
      ser_tx_oe_n_o <= deep;
    end
  end

  assign ser_tx_o = tx_q;

  // Fixed pattern verifier
  logic  fix_sync;
  logic  vphase;
  char_t fix_exp;
  logic  fix_hit;

  assign fix_exp = pat_sel == `PAT_HIGH ? `CHAR_HIGH :
                   pat_sel == `PAT_LOW  ? `CHAR_LOW  :
                   vphase ? `CHAR_MIX_B : `CHAR_MIX_A;
  assign fix_hit = pat_sel == `PAT_MIXED ? rx_char == `CHAR_MIX_A : rx_char == fix_exp;
  wire fix_err = ver_on && fix_mode && fix_sync && rx_char != fix_exp;

  always_ff @(posedge clk_i) begin
    if (srst || !ver_on || !fix_mode) begin
      fix_sync <= 1'b0;
      vphase   <= 1'b0;
    end else if (!fix_sync) begin
      fix_sync <= fix_hit;
      vphase   <= 1'b1;
    end else begin
      vphase   <= !vphase;
    end
  end

  // Random packet verifier
  logic       cr_sync;
  logic       cv_in;
  logic [7:0] cv_cnt;

  wire cr_err = ver_on && cr_mode && cr_sync && cv_in &&
                rx_char != cr_payload(cv_cnt);

  always_ff @(posedge clk_i) begin
    if (srst || !ver_on || !cr_mode) begin
      cr_sync <= 1'b0;
      cv_in   <= 1'b0;
      cv_cnt  <= '0;
    end else if (rx_char == `CHAR_SFD) begin
      cr_sync <= 1'b1;
      cv_in   <= 1'b1;
      cv_cnt  <= '0;
    end else if (cv_in) begin
      cv_in   <= cv_cnt != cr_len - 8'h01;
      cv_cnt  <= cv_cnt + 8'h01;
    end
  end

  // Pseudo-random verifier predicts each character from the one before.
  char_t      pv_prev;
  logic       pv_primed;
  logic [16:0] prbs_rx;

  assign prbs_rx = prbs_step(pv_prev[6:0]);
  wire prbs_err = prbs_ver && pv_primed && rx_char != prbs_rx[9:0];

  always_ff @(posedge clk_i) begin
    if (srst || !prbs_ver) begin
      pv_prev   <= '0;
      pv_primed <= 1'b0;
    end else begin
      pv_prev   <= rx_char;
      pv_primed <= 1'b1;
    end
  end

  // Error counters
  logic [15:0] tpe_cnt;
  logic [31:0] cr_cnt;
  logic [15:0] prh_cnt;
  logic [15:0] prl_cnt;

  sat_counter #(.W(16), .RST(`TPE_CNT_RST)) u_tpe (
    .clk_i   (clk_i),
    .rst_i   (srst),
    .inc_i   (fix_err),
    .clr_i   (rd_tpe),
    .count_o (tpe_cnt)
  );

  sat_counter #(.W(32), .RST(`CR_CNT_RST)) u_cr (
    .clk_i   (clk_i),
    .rst_i   (srst),
    .inc_i   (cr_err),
    .clr_i   (rd_crh),
    .count_o (cr_cnt)
  );

  sat_counter #(.W(16), .RST(`PRBS_CNT_RST)) u_prh (
    .clk_i   (clk_i),
    .rst_i   (srst),
    .inc_i   (prbs_err && rate_1g),
    .clr_i   (rd_prh),
    .count_o (prh_cnt)
  );

  sat_counter #(.W(16), .RST(`PRBS_CNT_RST)) u_prl (
    .clk_i   (clk_i),
    .rst_i   (srst),
    .inc_i   (prbs_err && rate_fx),
    .clr_i   (rd_prl),
    .count_o (prl_cnt)
  );

  // The lower half is frozen when the upper half is read, so both halves
  // belong to one count; a lone read of 24 returns the last frozen value.
  always_ff @(posedge clk_i) begin
    if (srst) begin
      cr_lo_shadow <= '0;
    end else if (rd_crh) begin
      cr_lo_shadow <= cr_cnt[15:0];
    end
  end

  // Read data
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    unique case (addr_i)
      `REG_CTRL: next_rdata = ctrl;
      `REG_STAT: next_rdata = 16'(link_s2) << `STAT_LINK;
      `REG_CH0:  next_rdata = ch0;
      `REG_CH1:  next_rdata = ch1;
      `REG_TPC:  next_rdata = tpc;
      `REG_TPS:  next_rdata = {14'h0000, fix_sync, cr_sync};
      `REG_TPE:  next_rdata = tpe_cnt;
      `REG_CRH:  next_rdata = cr_cnt[31:16];
      `REG_CRL:  next_rdata = cr_lo_shadow;
      `REG_PRH:  next_rdata = prh_cnt;
      `REG_PRL:  next_rdata = prl_cnt;
      default:   next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst) begin
      rdata_o        <= '0;
      pcs_enable_o   <= 1'b0;
      comma_detect_o <= 1'b0;
      rx_decode_en_o <= 1'b0;
      auto_neg_en_o  <= 1'b0;
      auto_rate_en_o <= 1'b0;
    end else begin
      rdata_o        <= rd_i ? next_rdata : '0;
      pcs_enable_o   <= ch0[`CH0_PCS_EN];
      comma_detect_o <= ch0[`CH0_COMMA];
      rx_decode_en_o <= ch1[`CH1_RX_DEC];
      auto_neg_en_o  <= ctrl[`CTRL_ANEG];
      auto_rate_en_o <= ch0[`CH0_AUTO_RATE];
    end
  end

endmodule : link_test_pattern_loopback

// [sim/link_test_props.sv]
/*
  Port checker for the test and loopback block; it mirrors the control
  bits from register writes. Assumes a register master that never waits.
*/
`include "link_test_map.svh"

module link_test_props
  import link_test_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register port
  input wire logic [4:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  // Data, pins and controls
  input wire logic [9:0]  tx_data_i,
  input wire logic [9:0]  rx_data_o,
  input wire logic        rx_oe_n_o,
  input wire logic [9:0]  ser_rx_i,
  input wire logic [9:0]  ser_tx_o,
  input wire logic        ser_tx_oe_n_o,
  input wire logic        all_channel_loop_pin_i,
  input wire logic        link_ok_i,
  input wire logic        pcs_enable_o,
  input wire logic        comma_detect_o,
  input wire logic        rx_decode_en_o,
  input wire logic        auto_neg_en_o,
  input wire logic        auto_rate_en_o
);
  logic        srst;
  logic        live;
  logic [9:0]  pt;
  logic [15:0] c0;
  logic [15:0] c16;
  logic [4:0]  tp;
  wire  [19:0] s    = {pt, ser_tx_o};
  wire         far  = c16[`CH0_FAR_END];
  wire         shl  = c16[`CH0_SHALLOW];
  wire         deep = c0[`CTRL_DEEP_LOOP];
  wire         gen  = c16[`CH0_PRBS_GEN] && !far;
  wire         fix  = tp[`TPC_GEN_EN] && tp[2:1] == 2'h0 && !gen && !far;

  // The soft reset lands one edge after its write, so the mirror follows it.
  always_ff @(posedge clk_i) begin
    srst <= wr_i && addr_i == `REG_CTRL && wdata_i[`CTRL_SOFT_RST];
    live <= !(rst_i || srst);
    pt   <= ser_tx_o;
    if (rst_i || srst) begin
      c0  <= `CTRL_RST;
      c16 <= `CH0_RST;
      tp  <= 5'h00;
    end else if (wr_i) begin
      if (addr_i == `REG_CTRL) c0 <= wdata_i;
      if (addr_i == `REG_CH0) c16 <= wdata_i;
      if (addr_i == `REG_TPC) tp <= wdata_i[4:0];
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence far_held;
    live && $past(live) && $past(far);
  endsequence

  sequence gen_held;
    live && $past(live) && $past(gen) && $past(gen, 2);
  endsequence

  a_deep_float: assert property (live && $past(deep) |-> ser_tx_oe_n_o)
    else $error("serial output driven in deep loopback");
  a_deep_data: assert property (
    live && $past(deep && !shl) |-> rx_data_o == $past(ser_tx_o))
    else $error("deep loopback data wrong");
  a_shallow_data: assert property (
    live && $past(shl) |-> rx_data_o == $past(tx_data_i))
    else $error("shallow loopback data wrong");
  a_far_data: assert property (far_held |-> ser_tx_o == $past(ser_rx_i, 3))
    else $error("far end loopback data wrong");
  a_par_float: assert property (
    live |-> rx_oe_n_o == $past(far && c0[`CTRL_PAR_HIZ]))
    else $error("parallel output enable wrong");
  a_prbs_seq: assert property (gen_held |-> (s[9:0] ^ s[15:6] ^ s[16:7]) == 10'h000)
    else $error("sequence generator output wrong");
  a_fixed_char: assert property (
    live && $past(live) && $past(fix) && $past(fix, 2) && $past(tp) == $past(tp, 2)
    |-> ser_tx_o == ($past(tp[0]) ? `CHAR_LOW : `CHAR_HIGH))
    else $error("fixed pattern character wrong");
  a_static_ctrl: assert property (live |-> pcs_enable_o == $past(c16[`CH0_PCS_EN])
    && comma_detect_o == $past(c16[`CH0_COMMA]) && auto_neg_en_o == $past(c0[`CTRL_ANEG])
    && auto_rate_en_o == $past(c16[`CH0_AUTO_RATE]))
    else $error("static control output wrong");
endmodule : link_test_props

bind link_test_pattern_loopback link_test_props props_u (.*);

// [sim/far_link_model.sv]
/*
  Far end of the serial link: echoes the channel's output or sends a
  fixed character, and corrupts characters on request.
*/
module far_link_model (
  // Clock
  input  wire logic       clk_i,
  // Line
  input  wire logic [9:0] line_in_i,
  input  wire logic       line_off_i,
  output logic [9:0]      line_out_o,
  // Test controls
  input  wire logic       echo_i,
  input  wire logic [9:0] fix_i,
  input  wire logic       err_i
);
  timeunit 1ns;
  timeprecision 1ns;

  // A released line rests at its pull-up level, so it reads as all ones.
  always_ff @(posedge clk_i) begin
    line_out_o <= (echo_i ? (line_off_i ? 10'h3ff : line_in_i) : fix_i) ^ {9'h0, err_i};
  end
endmodule : far_link_model

// [sim/link_test_pattern_loopback_tb.sv]
/*
  Self-checking bench for the test and loopback block. Assumes the far
  link model closes the serial side and the checker is bound in.
*/
`include "link_test_map.svh"

module link_test_pattern_loopback_tb
  import link_test_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic w; logic [4:0] a; logic [15:0] d; logic [15:0] m; logic [15:0] e;} row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        loop = 1'b0;
  logic        echo = 1'b1;
  logic        err = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] v;
  logic        link = 1'b1;
  char_t       tx = 10'h000;
  char_t       fix = 10'h000;
  char_t       rx;
  char_t       stx;
  char_t       srx;
  logic        rx_oe_n;
  logic        stx_oe_n;
  logic        dec;
  int          fail_count = 0;
  int          compares = 0;
  row_s rows[15] = '{
    '{0, `REG_CTRL, 0, 16'hffff, `CTRL_RST},
    '{0, `REG_STAT, 0, 16'h0004, 16'h0004},
    '{0, `REG_CH0, 0, 16'hffff, `CH0_RST},
    '{0, `REG_CH1, 0, 16'hffff, `CH1_RST},
    '{0, `REG_TPC, 0, 16'hffff, 16'h0000},
    '{0, `REG_TPE, 0, 16'hffff, `TPE_CNT_RST},
    '{0, `REG_CRH, 0, 16'hffff, 16'h0000},
    '{0, `REG_CRL, 0, 16'hffff, 16'h0000},
    '{0, `REG_PRH, 0, 16'hffff, `PRBS_CNT_RST},
    '{0, `REG_PRH, 0, 16'hffff, 16'h0000},
    '{0, `REG_PRL, 0, 16'hffff, `PRBS_CNT_RST},
    '{0, 5'h03, 0, 16'hffff, 16'h0000},
    '{1, `REG_CH0, 16'hffff, 16'hffff, `CH0_MASK},
    '{1, `REG_TPC, 16'hffff, 16'hffff, `TPC_MASK},
    '{1, `REG_CH1, 16'h0000, 16'hffff, 16'h0000}
  };

  link_test_pattern_loopback dut_u (.clk_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_data_i(tx),
    .rx_data_o(rx), .rx_oe_n_o(rx_oe_n), .ser_rx_i(srx), .ser_tx_o(stx),
    .ser_tx_oe_n_o(stx_oe_n), .all_channel_loop_pin_i(loop), .link_ok_i(link),
    .pcs_enable_o(), .comma_detect_o(), .rx_decode_en_o(dec), .auto_neg_en_o(),
    .auto_rate_en_o());
  far_link_model link_u (.clk_i(clk), .line_in_i(stx), .line_off_i(stx_oe_n),
    .line_out_o(srx), .echo_i(echo), .fix_i(fix), .err_i(err));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic put(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : put

  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  task automatic get(input logic [4:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : get

  task automatic look(input string what, input logic [4:0] a, input logic [15:0] exp);
    get(a, v);
    check(what, exp, v);
  endtask : look

  task automatic inject(input int n);
    err <= 1'b1;
    tick(n);
    err <= 1'b0;
    tick(10);
  endtask : inject

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    tick(3);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) put(rows[i].a, rows[i].d);
      get(rows[i].a, v);
      check($sformatf("register %h", rows[i].a), rows[i].e, v & rows[i].m);
    end
    check("decoder enable", 16'h0000, {15'h0, dec});
    link <= 1'b0;
    tick(3);
    look("link down", `REG_STAT, 16'h0000);
    link <= 1'b1;
    $display("test registers done");
    put(`REG_CTRL, 16'h8000);
    tick(2);
    look("ctrl after soft reset", `REG_CTRL, `CTRL_RST);
    look("ch0 after soft reset", `REG_CH0, `CH0_RST);
    put(`REG_CH0, 16'h1224);
    tx <= 10'h2b3;
    tick(3);
    @(negedge clk);
    check("shallow loop", 16'h02b3, {6'h00, rx});
    @(posedge clk);
    $display("test soft reset and shallow loop done");
    put(`REG_CTRL, 16'h0040);
    put(`REG_CH0, 16'h1000);
    put(`REG_CH1, 16'h0000);
    for (int p = 0; p < 3; p++) begin
      put(`REG_TPC, 16'h0010 | 16'(p));
      tick(10);
      get(`REG_TPE, v);
      put(`REG_TPC, 16'h0018 | 16'(p));
      tick(20);
      get(`REG_TPS, v);
      check("fixed sync", 16'h0002, v & 16'h0002);
      look("fixed errors", `REG_TPE, 16'h0000);
    end
    put(`REG_TPC, 16'h0018);
    tick(20);
    get(`REG_TPE, v);
    inject(3);
    look("fixed count", `REG_TPE, 16'h0003);
    look("fixed cleared", `REG_TPE, 16'h0000);
    put(`REG_TPC, 16'h0008);
    inject(3);
    look("stopped count", `REG_TPE, 16'h0000);
    $display("test fixed patterns done");
    for (int p = 3; p < 5; p++) begin
      put(`REG_TPC, 16'h0018 | 16'(p));
      tick(600);
      get(`REG_TPS, v);
      check("packet sync", 16'h0001, v & 16'h0001);
      look("packet upper", `REG_CRH, 16'h0000);
      look("packet lower", `REG_CRL, 16'h0000);
    end
    // Errors start on the first payload character after a clean delimiter.
    do @(negedge clk); while (stx !== `CHAR_SFD);
    @(posedge clk);
    inject(5);
    look("packet upper", `REG_CRH, 16'h0000);
    look("packet lower", `REG_CRL, 16'h0005);
    look("packet shadow", `REG_CRL, 16'h0005);
    look("packet upper cleared", `REG_CRH, 16'h0000);
    $display("test packet patterns done");
    put(`REG_TPC, 16'h0000);
    put(`REG_CTRL, 16'h4040);
    put(`REG_CH0, 16'h00c0);
    tick(10);
    get(`REG_PRH, v);
    tick(30);
    check("serial float", 16'h0001, {15'h0, stx_oe_n});
    look("deep errors", `REG_PRH, 16'h0000);
    put(`REG_CTRL, 16'h0040);
    loop <= 1'b1;
    tick(5);
    check("pin float", 16'h0001, {15'h0, stx_oe_n});
    loop <= 1'b0;
    tick(10);
    get(`REG_PRH, v);
    get(`REG_PRL, v);
    inject(1);
    look("gigabit errors", `REG_PRH, 16'h0002);
    look("fiber idle", `REG_PRL, 16'h0000);
    put(`REG_CTRL, 16'h2000);
    tick(10);
    get(`REG_PRL, v);
    inject(1);
    look("fiber errors", `REG_PRL, 16'h0002);
    look("gigabit idle", `REG_PRH, 16'h0000);
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    @(posedge clk);
    put(`REG_CTRL, 16'h0040);
    put(`REG_CH0, 16'h00c0);
    inject(12);
    look("saturated", `REG_PRH, 16'hffff);
    look("read clear", `REG_PRH, 16'h0000);
    $display("test sequence done");
    echo <= 1'b0;
    fix <= 10'h1a5;
    put(`REG_CTRL, 16'h0440);
    put(`REG_CH0, 16'h1124);
    tick(8);
    @(negedge clk);
    check("far end out", 16'h01a5, {6'h00, stx});
    check("parallel float", 16'h0001, {15'h0, rx_oe_n});
    $display("test far end done");
    give_verdict();
  end
endmodule : link_test_pattern_loopback_tb
